// [pkg/sar_conv_map.vh]
`ifndef SAR_CONV_MAP_VH
`define SAR_CONV_MAP_VH

// Result format
`define RES_BITS 18
`define RES_MSB 17
`define CODE_MAX 18'h1FFFF
`define CODE_MIN 18'h20000
`define CODE_ZERO 18'h00000

// Clock and conversion timing
`define CLK_PERIOD_NS 10
// Internal conversion clock divider: one bit decision per tick
`define CONV_DIV 4'h2
// Acquisition time required before a new start is honoured, in ns
`define T_ACQ_NS 100
`define ACQ_CYCLES ((`T_ACQ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Power-up settling in low-power mode, in ns
`define T_WAKE_NS 30
`define WAKE_CYCLES ((`T_WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Fast mode: 2 MSPS -> 500 ns; low power: 1.5 MSPS -> 666 ns
`define T_FAST_PERIOD_NS 500
`define T_SLOW_PERIOD_NS 666

`endif

// [test/sar_adc_conversion_control_props.sv]
`timescale 1ns/1ns
`default_nettype none
module sar_props (
  input wire logic mclk, rst, fast_mode, over_range, under_range,
  input wire logic sample_hold, power_up, busy, conv_done, result_valid,
  input wire logic [17:0] dac_code, result
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_go; $rose(sample_hold); endsequence
  property p_go; s_go |-> busy && dac_code == 18'h20000; endproperty
  a_go: assert property (p_go) else $error("bad start");
  // Powered before the start: fast path, first decision two cycles on
  property p_msb; s_go && $past(power_up) |-> ##2 dac_code[16];
  endproperty
  a_msb: assert property (p_msb) else $error("bad order");
  // Woken at the start: wake wait comes before the first decision
  property p_msb_wake; s_go && !$past(power_up) |-> ##6 dac_code[16];
  endproperty
  a_msb_wake: assert property (p_msb_wake) else $error("bad wake");
  property p_len; s_go |-> ##[30:45] conv_done; endproperty
  a_len: assert property (p_len) else $error("slow");
  property p_hold; s_go |-> sample_hold[*8]; endproperty
  a_hold: assert property (p_hold) else $error("restart");
  property p_done; conv_done |-> !busy && !sample_hold ##1 !conv_done;
  endproperty
  a_done: assert property (p_done) else $error("bad done");
  property p_fast; fast_mode[*8] |-> power_up; endproperty
  a_fast: assert property (p_fast) else $error("fast off");
  property p_low; (!fast_mode && !busy)[*8] |-> !power_up; endproperty
  a_low: assert property (p_low) else $error("idle on");
  property p_max; conv_done && over_range |-> result == 18'h1FFFF;
  endproperty
  a_max: assert property (p_max) else $error("no max");
  property p_min;
    conv_done && under_range && !over_range |-> result == 18'h20000;
  endproperty
  a_min: assert property (p_min) else $error("no min");
  property p_vld; conv_done && !fast_mode |-> result_valid; endproperty
  a_vld: assert property (p_vld) else $error("invalid");
endmodule
bind sar_adc_conversion_control sar_props sar_props_inst (.mclk, .rst,
  .fast_mode, .over_range, .under_range, .sample_hold, .power_up, .busy,
  .conv_done, .result_valid, .dac_code, .result);
`default_nettype wire

// [test/sar_adc_conversion_control_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module sar_adc_conversion_control_tb;
  logic mclk = 0, rst = 1, convert_start = 0, fast_mode = 0;
  logic over_range = 0, under_range = 0, comp_out;
  logic sample_hold, power_up, busy, conv_done, result_valid;
  logic [17:0] dac_code, result, level = 0;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  sar_adc_conversion_control sar_adc_conversion_control_inst (.mclk, .rst,
    .convert_start, .fast_mode, .comp_out, .over_range, .under_range,
    .sample_hold, .dac_code, .power_up, .busy, .conv_done, .result_valid,
    .result);
  sar_front_model sar_front_model_inst (.dac_code, .level, .comp_out);
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("mismatches=%0d checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task do_reset;
    @(posedge mclk) #1 rst = 1;
    repeat (4) @(posedge mclk);
    #1 rst = 0;
    repeat (10) @(posedge mclk);
  endtask
  task conv(input logic [17:0] lv, input logic [17:0] ex, input logic v);
    int i;
    @(posedge mclk) #1 level = lv;
    convert_start = 1;
    for (i = 0; i < 100 && conv_done !== 1'b1; i++) begin
      @(posedge mclk) #1;
      if (i == 3) convert_start = 0;
      // Second edge lands mid-conversion
      if (i == 9) convert_start = 1;
    end
    samples_checked++;
    if (i >= 100 || result !== ex || result_valid !== v) begin
      mismatches++;
      $display("[ERR] %0t code %h valid %b", $time, result, result_valid);
    end
    @(posedge mclk) #1 convert_start = 0;
    repeat (14) @(posedge mclk);
    #1;
  endtask
  task low_power_codes;
    conv(18'h20000, 18'h00000, 1);
    conv(18'h20001, 18'h00001, 1);
    conv(18'h1FFFF, 18'h3FFFF, 1);
  endtask
  task saturation;
    conv(18'h3FFFF, 18'h1FFFF, 1);
    conv(18'h00000, 18'h20000, 1);
    over_range = 1;
    conv(18'h20000, 18'h1FFFF, 1);
    under_range = 1;
    conv(18'h20000, 18'h1FFFF, 1);
    over_range = 0;
    conv(18'h20000, 18'h20000, 1);
    under_range = 0;
  endtask
  task fast_first;
    fast_mode = 1;
    do_reset();
    conv(18'h20001, 18'h00001, 0);
    conv(18'h1FFFF, 18'h3FFFF, 1);
  endtask
  initial begin
    do_reset();
    low_power_codes();
    saturation();
    fast_first();
    report_and_stop();
  end
endmodule
`default_nettype wire

// [test/sar_front_model.sv]
`timescale 1ns/1ns
`default_nettype none
module sar_front_model (
  input wire logic [17:0] dac_code,
  input wire logic [17:0] level,
  output logic comp_out
);
  // Ties keep the trial bit, so an exact level converts exactly
  assign comp_out = level >= dac_code;
endmodule
`default_nettype wire

// [verilog/sar_adc_conversion_control.v]
// Behaviour
// - rising start after acquisition holds the sample and begins conversion
// - eighteen binary-weighted trial decisions from MSB down to LSB
// - after last decision: back to acquisition, latch code, pulse done
// - decisions paced by internal divided clock; serial clock plays no part
// - mode high selects fast mode, powered between conversions
// - mode low selects low-power mode, powered down between conversions
// - in low-power mode the first result is already valid
// - each result belongs to its own start sample, no pipeline latency
// - result is 18-bit two's complement, zero input gives zero code
// - at or above positive full scale minus one LSB gives 0x1FFFF
// - at or below negative full scale gives 0x20000
`timescale 1ns/1ns
`default_nettype none
`include "sar_conv_map.vh"

module sar_adc_conversion_control (
  input wire mclk,
  input wire rst,
  input wire convert_start,
  input wire fast_mode,
  input wire comp_out,
  input wire over_range,
  input wire under_range,
  output reg sample_hold,
  output reg [`RES_MSB:0] dac_code,
  output reg power_up,
  output reg busy,
  output reg conv_done,
  output reg result_valid,
  output reg [`RES_MSB:0] result
);

  localparam [3:0] ST_ACQ = 4'b0001;
  localparam [3:0] ST_WAKE = 4'b0010;
  localparam [3:0] ST_CONV = 4'b0100;
  localparam [3:0] ST_DONE = 4'b1000;
  localparam integer ACQ_INT = `ACQ_CYCLES;
  localparam integer WAKE_INT = `WAKE_CYCLES;
  // Counts fit in eight bits; cut the integer on purpose
  localparam [7:0] ACQ_CNT = ACQ_INT[7:0];
  localparam [7:0] WAKE_CNT = WAKE_INT[7:0];

  // Pin synchronisers: three stages, change taken when 2nd and 3rd agree
  reg [2:0] start_sync;
  reg [2:0] mode_sync;
  reg start_level;
  reg start_prev;
  reg mode_level;
  wire start_rise;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_sync <= 3'h0;
      mode_sync <= 3'h0;
      start_level <= 1'b0;
      mode_level <= 1'b0;
      start_prev <= 1'b0;
    end else begin
      start_sync <= {start_sync[1:0], convert_start};
      mode_sync <= {mode_sync[1:0], fast_mode};
      if (start_sync[1] == start_sync[2])
        start_level <= start_sync[2];
      if (mode_sync[1] == mode_sync[2])
        mode_level <= mode_sync[2];
      start_prev <= start_level;
    end
  end

  assign start_rise = start_level & ~start_prev;

  // Internal conversion clock enable
  reg [3:0] div_cnt;
  wire conv_tick;
  assign conv_tick = (div_cnt == `CONV_DIV - 4'h1);

  reg [3:0] state;
  reg [7:0] wait_cnt;
  reg [4:0] bit_idx;
  reg [`RES_MSB:0] trial;
  reg [`RES_MSB:0] next_trial;
  reg sat_hi;
  reg sat_lo;
  reg first_fast;

  // Offset-binary trial bit for index, as a one-hot mask
  function [`RES_MSB:0] bit_mask;
    input [4:0] idx;
    begin
      bit_mask = {{(`RES_BITS-1){1'b0}}, 1'b1} << idx;
    end
  endfunction

  always @* begin
    next_trial = trial;
    // Keep the trial bit if the comparator says input is above it
    if (!comp_out)
      next_trial = trial & ~bit_mask(bit_idx);
    if (bit_idx != 5'h0)
      next_trial = next_trial | bit_mask(bit_idx - 5'h1);
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_ACQ;
      div_cnt <= 4'h0;
      wait_cnt <= 8'h00;
      bit_idx <= 5'h0;
      trial <= 18'h00000;
      sat_hi <= 1'b0;
      sat_lo <= 1'b0;
      first_fast <= 1'b1;
      sample_hold <= 1'b0;
      dac_code <= 18'h00000;
      power_up <= 1'b0;
      busy <= 1'b0;
      conv_done <= 1'b0;
      result_valid <= 1'b0;
      result <= `CODE_ZERO;
    end else begin
      conv_done <= 1'b0;
      if (wait_cnt != 8'h00)
        wait_cnt <= wait_cnt - 8'h01;
      // Fast mode keeps the core powered between conversions
      if (state == ST_ACQ)
        power_up <= mode_level;
      case (state)
        ST_ACQ: begin
          sample_hold <= 1'b0;
          if (start_rise && wait_cnt == 8'h00) begin
            sample_hold <= 1'b1;
            busy <= 1'b1;
            sat_hi <= over_range;
            sat_lo <= under_range;
            div_cnt <= 4'h0;
            bit_idx <= 5'd`RES_MSB;
            trial <= bit_mask(5'd`RES_MSB);
            dac_code <= bit_mask(5'd`RES_MSB);
            if (mode_level) begin
              state <= ST_CONV;
            end else begin
              // Low power: wake before deciding, so even the first is valid
              power_up <= 1'b1;
              wait_cnt <= WAKE_CNT;
              state <= ST_WAKE;
            end
          end
        end
        ST_WAKE: begin
          if (wait_cnt == 8'h00)
            state <= ST_CONV;
        end
        ST_CONV: begin
          // Paced by the internal divider only, no serial clock input
          if (conv_tick) begin
            div_cnt <= 4'h0;
            trial <= next_trial;
            dac_code <= next_trial;
            if (bit_idx == 5'h0)
              state <= ST_DONE;
            else
              bit_idx <= bit_idx - 5'h1;
          end else begin
            div_cnt <= div_cnt + 4'h1;
          end
          // Start edges here are dropped by not being looked at
        end
        ST_DONE: begin
          state <= ST_ACQ;
          sample_hold <= 1'b0;
          busy <= 1'b0;
          conv_done <= 1'b1;
          wait_cnt <= ACQ_CNT;
          if (!mode_level)
            power_up <= 1'b0;
          // Offset binary to two's complement by MSB flip
          if (sat_hi)
            result <= `CODE_MAX;
          else if (sat_lo)
            result <= `CODE_MIN;
          else
            result <= {~trial[`RES_MSB], trial[`RES_MSB-1:0]};
          // First fast-mode result is flagged not valid for the host
          result_valid <= ~(mode_level & first_fast);
          if (mode_level)
            first_fast <= 1'b0;
        end
        default: state <= ST_ACQ;
      endcase
    end
  end

endmodule
`default_nettype wire
